// >>> verilog/sbc_top.sv
/*
   Serial port front end: clock mode selection, transmit write buffer and shift
   register, receiver with clock recovery and a two-entry receive FIFO.
   Assumes the divisor, format and mode bits are held by registers outside and
   that all inputs are synchronous to ref_clk.
*/

// ==========================================================
// usage notes

// the baud counter starts at zero, so the first tick
// comes on the first edge after reset and reloads

// asynchronous transmit bits run from a free prescaler, so the
// first start bit may wait up to one bit period

// a write while the buffer is full replaces the unsent
// character; software waits for data_reg_empty

// parity modes 0 and 1 both mean no parity bit

// the receiver checks only the first stop bit

// overrun is shown with the character after the
// lost one, not with the lost one itself

// a start bit high again at mid bit is noise and
// the receiver goes back to idle

// slave clock edges act three cycles after the pin
// moves: two synchroniser stages and the detector

// double speed is masked in synchronous mode, so a
// careless setting cannot bend the bit timing

// the fifo head reads as zero when empty, which
// keeps stale status off the flag outputs

// changing format bits mid frame corrupts a frame being
// received; the transmit frame is built at load, and nothing guards against it

`timescale 1ns/1ns
module sbc_top (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic sync_mode_select,
   input wire logic double_speed,
   input wire logic xfer_clock_pin_direction,
   input wire logic xfer_clock_polarity,
   input wire logic [3:0] baud_divisor_high,
   input wire logic [7:0] baud_divisor_low,
   input wire logic baud_divisor_low_write,
   input wire logic [3:0] data_bits,
   input wire logic [1:0] parity_mode,
   input wire logic two_stop_bits,
   input wire logic [8:0] tx_data,
   input wire logic tx_write,
   input wire logic tx_complete_clear,
   input wire logic rx_read,
   input wire logic rxd,
   input wire logic xfer_clock_pin_in,
   output logic txd,
   output logic xfer_clock_pin_out,
   output logic xfer_clock_pin_oe,
   output logic data_reg_empty,
   output logic tx_complete,
   output logic rx_complete,
   output logic [7:0] rx_data,
   output logic rx_ninth_bit,
   output logic frame_error_flag,
   output logic overrun_flag,
   output logic parity_error_flag
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [3:0] tx_pre;
      logic [3:0] rx_samp;
      sbc_pkg::sbc_tx_e tx_state;
      logic [12:0] tx_sh;
      logic [3:0] tx_left;
      logic [8:0] tx_buf;
      logic tx_full;
      logic txd;
      logic txc;
      sbc_pkg::sbc_rx_e rx_state;
      logic [3:0] rx_bit;
      logic [8:0] rx_sh;
      logic rx_par;
      logic pend;
      logic [8:0] pend_data;
      logic pend_fe;
      logic pend_pe;
      logic ovr_next;
      logic [1:0][11:0] mem;
      logic wr;
      logic rd;
      logic [1:0] cnt;
      logic [11:0] head;
      logic rxc;
      logic dre;
   } sbc_top_s;

   localparam sbc_top_s ST_RESET = '{
      tx_state: sbc_pkg::TX_IDLE,
      rx_state: sbc_pkg::RX_IDLE,
      txd: sbc_pkg::IDLE_LINE,
      dre: 1'b1,
      default: '0
   };

   sbc_top_s s;
   sbc_top_s next_s;
   sbc_clk_if ck ();

   logic async_mode;
   logic dbl;
   logic [3:0] last;
   logic [3:0] mid;
   logic tx_strobe;
   logic rx_start;
   logic samp_evt;
   logic [3:0] flen;

   // ==========================================================
   // clock generator
   assign ck.divisor = {baud_divisor_high, baud_divisor_low};
   assign ck.div_load = baud_divisor_low_write;
   assign ck.sync_mode = sync_mode_select;
   assign ck.clk_dir = xfer_clock_pin_direction;
   assign ck.clk_pol = xfer_clock_polarity;
   assign ck.xck_in = xfer_clock_pin_in;

   sbc_clkgen u_clkgen (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ck(ck.gen)
   );

   // ==========================================================
   // mode decode
   assign async_mode = ~sync_mode_select;
   // double speed is masked in synchronous mode in case software forgets
   assign dbl = double_speed & async_mode;
   assign last = dbl ? sbc_pkg::SAMP_LAST_DOUBLE : sbc_pkg::SAMP_LAST_NORMAL;
   assign mid = dbl ? sbc_pkg::SAMP_MID_DOUBLE : sbc_pkg::SAMP_MID_NORMAL;

   // transmit bit strobe: divided ticks async, change edge when synchronous
   assign tx_strobe = async_mode ? (ck.baud_tick && s.tx_pre == last) : ck.sync_change;

   // receive start detection and mid-bit or opposite-edge sampling
   assign rx_start = async_mode ? (ck.baud_tick & ~rxd) : (ck.sync_sample & ~rxd);
   assign samp_evt = async_mode ? (ck.baud_tick && s.rx_samp == mid) : ck.sync_sample;

   // frame length in bits: start, data, optional parity, one or two stops
   assign flen = data_bits + {3'h0, parity_mode[1]} + {3'h0, two_stop_bits} + 4'h2;

   // ==========================================================
   // frame builder, lsb first, parity right after the data
   function automatic logic [12:0] build_frame(
      input logic [8:0] d,
      input logic [3:0] nb,
      input logic [1:0] pm
   );
      logic [12:0] fb;
      logic par;
      fb = '1;
      fb[0] = 1'b0;
      par = (pm == sbc_pkg::PAR_ODD);
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < nb) begin
            fb[i + 1] = d[i];
            par = par ^ d[i];
         end
      end
      if (pm[1]) begin
         fb[nb + 4'h1] = par;
      end
      return fb;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      next_s = s;

      // dividers advance on every baud tick
      if (ck.baud_tick) begin
         next_s.tx_pre = (s.tx_pre == last) ? 4'h0 : s.tx_pre + 4'h1;
         next_s.rx_samp = (s.rx_samp == last) ? 4'h0 : s.rx_samp + 4'h1;
      end

      // ---- transmitter ----
      if (tx_complete_clear) begin
         next_s.txc = 1'b0;
      end
      if (tx_strobe) begin
         if (s.tx_state == sbc_pkg::TX_BUSY && s.tx_left != 4'h0) begin
            next_s.tx_sh = {1'b1, s.tx_sh[12:1]};
            next_s.tx_left = s.tx_left - 4'h1;
            next_s.txd = s.tx_sh[1];
         end else if (s.tx_full) begin
            // buffered byte follows the last stop bit directly
            next_s.tx_sh = build_frame(s.tx_buf, data_bits, parity_mode);
            next_s.tx_left = flen - 4'h1;
            next_s.txd = 1'b0;
            next_s.tx_full = 1'b0;
            next_s.tx_state = sbc_pkg::TX_BUSY;
         end else begin
            // set wins over a clear in the same cycle
            if (s.tx_state == sbc_pkg::TX_BUSY) begin
               next_s.txc = 1'b1;
            end
            next_s.txd = sbc_pkg::IDLE_LINE;
            next_s.tx_state = sbc_pkg::TX_IDLE;
         end
      end
      // a write while full overwrites the unsent byte
      if (tx_write) begin
         next_s.tx_buf = tx_data;
         next_s.tx_full = 1'b1;
      end

      // ---- receive fifo push and pop ----
      if (s.pend && s.cnt != sbc_pkg::FIFO_DEPTH) begin
         next_s.mem[s.wr] = {s.ovr_next, s.pend_pe, s.pend_fe, s.pend_data};
         next_s.wr = ~s.wr;
         next_s.pend = 1'b0;
         next_s.ovr_next = 1'b0;
         next_s.cnt = next_s.cnt + 2'h1;
      end
      if (rx_read && s.cnt != 2'h0) begin
         next_s.rd = ~s.rd;
         next_s.cnt = next_s.cnt - 2'h1;
      end

      // ---- receiver ----
      case (s.rx_state)
         sbc_pkg::RX_IDLE: begin
            if (rx_start) begin
               // a waiting char is lost once the next start arrives
               if (next_s.pend) begin
                  next_s.pend = 1'b0;
                  next_s.ovr_next = 1'b1;
               end
               next_s.rx_samp = 4'h1;
               next_s.rx_bit = 4'h0;
               next_s.rx_par = (parity_mode == sbc_pkg::PAR_ODD);
               next_s.rx_state = async_mode ? sbc_pkg::RX_START : sbc_pkg::RX_BITS;
            end
         end
         sbc_pkg::RX_START: begin
            // high at mid start bit is a glitch, not a frame
            if (samp_evt) begin
               next_s.rx_state = rxd ? sbc_pkg::RX_IDLE : sbc_pkg::RX_BITS;
            end
         end
         sbc_pkg::RX_BITS: begin
            if (samp_evt) begin
               next_s.rx_bit = s.rx_bit + 4'h1;
               if (s.rx_bit < data_bits) begin
                  next_s.rx_sh = {rxd, s.rx_sh[8:1]};
                  next_s.rx_par = s.rx_par ^ rxd;
               end else if (parity_mode[1] && s.rx_bit == data_bits) begin
                  next_s.rx_par = s.rx_par ^ rxd;
               end else begin
                  // only the first stop bit is checked
                  next_s.pend = 1'b1;
                  next_s.pend_data = s.rx_sh >> (sbc_pkg::BITS_MAX - data_bits);
                  next_s.pend_fe = ~rxd;
                  next_s.pend_pe = parity_mode[1] & s.rx_par;
                  next_s.rx_state = sbc_pkg::RX_IDLE;
               end
            end
         end
         default: begin
            next_s.rx_state = sbc_pkg::RX_IDLE;
         end
      endcase

      // ---- visible fifo head and status levels ----
      next_s.head = (next_s.cnt != 2'h0) ? next_s.mem[next_s.rd] : 12'h000;
      next_s.rxc = (next_s.cnt != 2'h0);
      next_s.dre = ~next_s.tx_full;
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= ST_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops
   assign txd = s.txd;
   assign xfer_clock_pin_out = ck.xck_out;
   assign xfer_clock_pin_oe = ck.xck_oe;
   assign data_reg_empty = s.dre;
   assign tx_complete = s.txc;
   assign rx_complete = s.rxc;
   assign rx_data = s.head[7:0];
   assign rx_ninth_bit = s.head[8];
   assign frame_error_flag = s.head[9];
   assign parity_error_flag = s.head[10];
   assign overrun_flag = s.head[11];

endmodule

// >>> verilog/sbc_pkg.sv
/*
   Shared constants and types of the serial baud clock and receive buffer block.
   Assumes a single system clock; every divider count here is in system clock cycles or baud ticks.
*/
package sbc_pkg;

   // ==========================================================
   // widths and limits
   localparam int DIV_W = 12;
   localparam logic [3:0] BITS_MAX = 4'h9;
   localparam int FRAME_W = 13;

   // ==========================================================
   // baud tick dividers: last state and mid-bit sample state
   localparam logic [3:0] SAMP_LAST_NORMAL = 4'hF;
   localparam logic [3:0] SAMP_LAST_DOUBLE = 4'h7;
   localparam logic [3:0] SAMP_MID_NORMAL = 4'h7;
   localparam logic [3:0] SAMP_MID_DOUBLE = 4'h3;

   // ==========================================================
   // frame and receive fifo options
   localparam logic [1:0] PAR_ODD = 2'h3;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;

   // ==========================================================
   // values after reset
   localparam logic IDLE_LINE = 1'b1;
   localparam logic [DIV_W-1:0] BAUD_CNT_RESET = 12'h000;

   typedef enum logic {TX_IDLE, TX_BUSY} sbc_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} sbc_rx_e;

endpackage

// >>> verilog/sbc_clk_if.sv
/*
   Carrier between the clock generator and the transmit/receive engine.
   Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface sbc_clk_if;
   logic [11:0] divisor;
   logic div_load;
   logic sync_mode;
   logic clk_dir;
   logic clk_pol;
   logic xck_in;
   logic baud_tick;
   logic sync_change;
   logic sync_sample;
   logic xck_out;
   logic xck_oe;

   modport gen (input divisor, div_load, sync_mode, clk_dir, clk_pol, xck_in,
                output baud_tick, sync_change, sync_sample, xck_out, xck_oe);
   modport eng (output divisor, div_load, sync_mode, clk_dir, clk_pol, xck_in,
                input baud_tick, sync_change, sync_sample, xck_out, xck_oe);
endinterface

// >>> verilog/sbc_clkgen.sv
/*
   Clock generator: baud down-counter, master transfer clock, slave clock
   synchroniser and edge detector. Assumes configuration inputs are synchronous.
*/
`timescale 1ns/1ns
module sbc_clkgen (
   input wire logic ref_clk,
   input wire logic reset_n,
   sbc_clk_if.gen ck
);

   typedef struct packed {
      logic [11:0] cnt;
      logic xcko;
      logic xs1;
      logic xs2;
      logic xs3;
      logic xoe;
   } sbc_clkgen_s;

   sbc_clkgen_s s;
   sbc_clkgen_s next_s;
   logic master;
   logic slave;
   logic rise;
   logic fall;

   // ==========================================================
   // mode decode: the pin only matters in synchronous mode
   assign master = ck.sync_mode & ck.clk_dir;
   assign slave = ck.sync_mode & ~ck.clk_dir;
   assign ck.baud_tick = (s.cnt == 12'h000);

   // slave edges come from the second and third stages, never the first
   assign rise = master ? (ck.baud_tick & ~s.xcko) : (slave & s.xs2 & ~s.xs3);
   assign fall = master ? (ck.baud_tick & s.xcko) : (slave & ~s.xs2 & s.xs3);
   assign ck.sync_change = ck.clk_pol ? fall : rise;
   assign ck.sync_sample = ck.clk_pol ? rise : fall;
   assign ck.xck_out = s.xcko;
   // registered so the pin enable leaves a flip-flop like the clock pin output; tick and edge strobes are combinational
   assign ck.xck_oe = s.xoe;

   // ==========================================================
   // next state
   always_comb begin
      next_s = s;
      // reload at zero or when the low divisor byte is written
      if (ck.baud_tick || ck.div_load) begin
         next_s.cnt = ck.divisor;
      end else begin
         next_s.cnt = s.cnt - 12'h001;
      end
      // master clock toggles per baud tick, so a full period is two ticks
      if (master) begin
         if (ck.baud_tick) begin
            next_s.xcko = ~s.xcko;
         end
      end else begin
         next_s.xcko = ck.clk_pol; // idle level follows polarity
      end
      next_s.xoe = master;
      next_s.xs1 = ck.xck_in;
      next_s.xs2 = s.xs1;
      next_s.xs3 = s.xs2;
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{cnt: sbc_pkg::BAUD_CNT_RESET, default: '0};
      end else begin
         s <= next_s;
      end
   end

endmodule

// >>> tb/sbc_chk_sva.sv
/*
   Checker for the serial front end, watching the top ports only.
   Assumes one clock, reset_n async active low, bound onto sbc_top.
*/
`timescale 1ns/1ns
module sbc_chk (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic sync_mode_select,
   input wire logic xfer_clock_pin_direction,
   input wire logic [3:0] baud_divisor_high,
   input wire logic [7:0] baud_divisor_low,
   input wire logic baud_divisor_low_write,
   input wire logic tx_write,
   input wire logic tx_complete_clear,
   input wire logic rx_read,
   input wire logic txd,
   input wire logic xfer_clock_pin_out,
   input wire logic xfer_clock_pin_oe,
   input wire logic data_reg_empty,
   input wire logic tx_complete,
   input wire logic rx_complete,
   input wire logic [7:0] rx_data,
   input wire logic frame_error_flag,
   input wire logic overrun_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic master;
   logic armed;
   logic [11:0] gap;
   assign master = sync_mode_select & xfer_clock_pin_direction;
   // cycles since the last master clock edge; a reload restarts the phase, so disarm
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         armed <= 1'b0;
         gap <= 12'h000;
      end else if (!master || baud_divisor_low_write) begin
         armed <= 1'b0;
         gap <= 12'h000;
      end else if ($changed(xfer_clock_pin_out)) begin
         armed <= 1'b1;
         gap <= 12'h000;
      end else begin
         gap <= gap + 12'h001;
      end
   end
   // ==========================================================
   // properties
   sequence s_load;
      tx_write && data_reg_empty;
   endsequence
   sequence s_done;
      $rose(tx_complete);
   endsequence
   property p_oe;
      xfer_clock_pin_oe == $past(master);
   endproperty
   property p_load;
      s_load |=> !data_reg_empty;
   endproperty
   property p_start;
      $rose(data_reg_empty) |-> !txd;
   endproperty
   property p_done;
      s_done |-> txd && data_reg_empty;
   endproperty
   property p_sticky;
      tx_complete && !tx_complete_clear |=> tx_complete;
   endproperty
   property p_head;
      rx_complete && !rx_read |=> rx_complete && $stable(rx_data) && $stable(overrun_flag);
   endproperty
   property p_empty;
      !rx_complete |-> rx_data == 8'h00 && !frame_error_flag && !overrun_flag;
   endproperty
   property p_period;
      master && armed && $changed(xfer_clock_pin_out) |-> gap == {baud_divisor_high, baud_divisor_low};
   endproperty
   a_oe: assert property (p_oe) else $error("clock pin enable wrong");
   a_load: assert property (p_load) else $error("write not taken");
   a_start: assert property (p_start) else $error("buffer moved without start bit");
   a_done: assert property (p_done) else $error("complete set mid frame");
   a_sticky: assert property (p_sticky) else $error("complete lost");
   a_head: assert property (p_head) else $error("fifo head moved");
   a_empty: assert property (p_empty) else $error("empty fifo shows data");
   a_period: assert property (p_period) else $error("master clock period wrong");
endmodule
bind sbc_top sbc_chk chk_u (.*);

// >>> tb/sbc_peer.sv
/*
   Remote serial peer: sends frames on the data line, async or clocked.
   Assumes the bench calls send from a negedge-aligned thread.
*/
`timescale 1ns/1ns
module sbc_peer (
   input wire logic ref_clk,
   output logic line,
   output logic xfer_clock_pin
);
   // idle high line, clock held still between frames
   initial begin
      line = 1'b1;
      xfer_clock_pin = 1'b0;
   end
   // one bit of bp cycles; in clocked mode data changes with the rising edge
   task automatic bit_out(input logic b, input int bp, input logic syn);
      @(negedge ref_clk);
      line <= b;
      if (syn) xfer_clock_pin <= 1'b1;
      repeat (bp / 2) @(negedge ref_clk);
      if (syn) xfer_clock_pin <= 1'b0; // far side samples on the opposite edge
      repeat (bp / 2 - 1) @(negedge ref_clk);
   endtask
   // bench keeps bp at 8 or more, so the clock stays under a quarter of ref_clk
   task automatic send(input logic [8:0] d, input logic [3:0] nb, input logic [1:0] pm,
                       input int bp, input logic stop_v, input logic syn);
      logic p;
      p = pm[0];
      bit_out(1'b0, bp, syn);
      for (int i = 0; i < nb; i++) begin
         bit_out(d[i], bp, syn);
         p ^= d[i];
      end
      if (pm[1]) bit_out(p, bp, syn);
      bit_out(stop_v, bp, syn);
      line <= 1'b1;
   endtask
endmodule

// >>> tb/tb_top.sv
/*
   Self-checking bench of sbc_top with a serial peer on the receive side.
   Assumes the checker is bound by its own file; inputs change at negedge.
*/
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
   $display("unexpected %s exp %0h got %0h", n, e, a); end end
module tb_top;
   typedef struct packed {logic ds; logic [11:0] dv; logic [8:0] d; logic [3:0] nb; logic [1:0] pm;} sbc_row_s;
   logic ref_clk, reset_n, sync_mode_select, double_speed, xfer_clock_pin_direction;
   logic xfer_clock_polarity, baud_divisor_low_write, two_stop_bits, tx_write;
   logic tx_complete_clear, rx_read, rxd, xfer_clock_pin_in, txd, xfer_clock_pin_out;
   logic xfer_clock_pin_oe, data_reg_empty, tx_complete, rx_complete, rx_ninth_bit;
   logic frame_error_flag, overrun_flag, parity_error_flag;
   logic [3:0] baud_divisor_high, data_bits;
   logic [7:0] baud_divisor_low, rx_data;
   logic [1:0] parity_mode;
   logic [8:0] tx_data;
   logic [11:0] got, got2;
   int err_total, checks_done, bp, k;
   sbc_row_s rows [4] = '{'{1'b0, 12'h003, 9'h0A5, 4'h8, 2'h0}, '{1'b1, 12'h002, 9'h13C, 4'h9, 2'h2},
                          '{1'b0, 12'h001, 9'h015, 4'h5, 2'h3}, '{1'b1, 12'h000, 9'h0FF, 4'h7, 2'h2}};
   sbc_top dut_u (.*);
   sbc_peer peer_u (.ref_clk(ref_clk), .line(rxd), .xfer_clock_pin(xfer_clock_pin_in));
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cfg(input logic s, ds, dr, input logic [11:0] dv, input logic [3:0] nb, input logic [1:0] pm);
      @(negedge ref_clk);
      {sync_mode_select, double_speed, xfer_clock_pin_direction} = {s, ds, dr};
      {baud_divisor_high, baud_divisor_low} = dv;
      data_bits = nb;
      parity_mode = pm;
      baud_divisor_low_write = 1'b1;
      @(negedge ref_clk);
      baud_divisor_low_write = 1'b0;
   endtask
   // expected line image: start, data lsb first, optional parity, stop
   function automatic logic [11:0] mkf(input logic [8:0] d, input logic [3:0] nb, input logic [1:0] pm);
      logic p;
      mkf = '0;
      p = pm[0];
      for (int i = 0; i < nb; i++) begin
         mkf[i + 1] = d[i];
         p ^= d[i];
      end
      mkf[nb + 1] = pm[1] ? p : 1'b1;
      if (pm[1]) mkf[nb + 2] = 1'b1;
   endfunction
   // samples txd mid-bit; find=0 means the next start is due one bit after the last stop
   task automatic grab(input logic find, input logic [3:0] nb, input logic [1:0] pm, output logic [11:0] g);
      int n;
      g = '0;
      n = 0;
      if (find) begin
         while (txd !== 1'b0 && n < 4000) begin
            @(negedge ref_clk);
            n++;
         end
         if (n >= 4000) begin
            err_total++;
            close_out();
         end
         repeat (bp / 2) @(negedge ref_clk);
      end else repeat (bp) @(negedge ref_clk);
      g[0] = txd;
      for (int i = 1; i <= nb + (pm[1] ? 2 : 1); i++) begin
         repeat (bp) @(negedge ref_clk);
         g[i] = txd;
      end
   endtask
   task automatic wait_rx();
      int n;
      n = 0;
      while (rx_complete !== 1'b1 && n < 800) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 800) begin
         err_total++;
         close_out();
      end
   endtask
   // status is checked before the pop, as software must
   task automatic rd(input logic [7:0] e, input logic ov, input logic fe);
      wait_rx();
      `CHK("rx_data", e, rx_data)
      `CHK("overrun", ov, overrun_flag)
      `CHK("frame_err", fe, frame_error_flag)
      rx_read = 1'b1;
      @(negedge ref_clk);
      rx_read = 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic wr(input logic [8:0] d);
      @(negedge ref_clk);
      tx_data = d;
      tx_write = 1'b1;
      @(negedge ref_clk);
      tx_write = 1'b0;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {reset_n, sync_mode_select, double_speed, xfer_clock_pin_direction, xfer_clock_polarity} = '0;
      {baud_divisor_low_write, two_stop_bits, tx_write, tx_complete_clear, rx_read} = '0;
      {baud_divisor_high, baud_divisor_low, data_bits, parity_mode, tx_data} = '0;
      err_total = 0;
      checks_done = 0;
      repeat (8) @(negedge ref_clk);
      `CHK("txd", 1'b1, txd)
      `CHK("flags", 3'h4, {data_reg_empty, tx_complete, rx_complete})
      reset_n = 1'b1;
      $display("test reset done");
      foreach (rows[r]) begin
         cfg(1'b0, rows[r].ds, 1'b0, rows[r].dv, rows[r].nb, rows[r].pm);
         bp = (rows[r].ds ? 8 : 16) * (int'(rows[r].dv) + 1);
         fork
            peer_u.send(rows[r].d ^ 9'h1FF, rows[r].nb, rows[r].pm, bp, 1'b1, 1'b0);
            begin
               wr(rows[r].d);
               grab(1'b1, rows[r].nb, rows[r].pm, got);
            end
         join
         `CHK("tx_frame", mkf(rows[r].d, rows[r].nb, rows[r].pm), got)
         wait_rx();
         `CHK("ninth", (rows[r].nb == 4'h9) & ~rows[r].d[8], rx_ninth_bit)
         `CHK("parity_err", 1'b0, parity_error_flag)
         rd(8'(((rows[r].d ^ 9'h1FF) & ((9'h001 << rows[r].nb) - 9'h001))), 1'b0, 1'b0);
         `CHK("rx_empty", 1'b0, rx_complete)
      end
      $display("test rows done");
      // second write lands while the first frame shifts: no gap allowed
      cfg(1'b0, 1'b0, 1'b0, 12'h001, 4'h8, 2'h0);
      bp = 32;
      fork
         grab(1'b1, 4'h8, 2'h0, got);
         begin
            wr(9'h03C);
            k = 0;
            while (data_reg_empty !== 1'b1 && k < 400) begin
               @(negedge ref_clk);
               k++;
            end
            if (k >= 400) begin
               err_total++;
               close_out();
            end
            wr(9'h0C3);
         end
      join
      grab(1'b0, 4'h8, 2'h0, got2);
      `CHK("first", mkf(9'h03C, 4'h8, 2'h0), got)
      `CHK("second", mkf(9'h0C3, 4'h8, 2'h0), got2)
      repeat (bp) @(negedge ref_clk);
      `CHK("tx_done", 1'b1, tx_complete)
      tx_complete_clear = 1'b1;
      @(negedge ref_clk);
      tx_complete_clear = 1'b0;
      @(negedge ref_clk);
      `CHK("tx_clear", 1'b0, tx_complete)
      $display("test back to back done");
      // three chars fit (two entries plus the pending register); a fourth start costs the held one
      cfg(1'b0, 1'b1, 1'b0, 12'h000, 4'h8, 2'h0);
      foreach (rows[r]) if (r < 3) peer_u.send(9'h011 * r, 4'h8, 2'h0, 8, 1'b1, 1'b0);
      repeat (40) @(negedge ref_clk);
      for (int r = 0; r < 3; r++) rd(8'h11 * r, 1'b0, 1'b0);
      foreach (rows[r]) peer_u.send(9'h041 + r, 4'h8, 2'h0, 8, 1'b1, 1'b0);
      repeat (40) @(negedge ref_clk);
      rd(8'h41, 1'b0, 1'b0);
      rd(8'h42, 1'b0, 1'b0);
      rd(8'h44, 1'b1, 1'b0);
      $display("test fifo done");
      // clocked slave, double speed kept clear though synchronous mode masks it
      cfg(1'b1, 1'b0, 1'b0, 12'h000, 4'h8, 2'h0);
      `CHK("oe_slave", 1'b0, xfer_clock_pin_oe)
      peer_u.send(9'h0B6, 4'h8, 2'h0, 20, 1'b1, 1'b1);
      rd(8'hB6, 1'b0, 1'b0);
      // clocked master: pin toggles once per baud tick
      cfg(1'b1, 1'b0, 1'b1, 12'h003, 4'h8, 2'h0);
      `CHK("oe_master", 1'b1, xfer_clock_pin_oe)
      repeat (20) @(negedge ref_clk);
      k = 0;
      for (int i = 0; i < 40; i++) begin
         got[0] = xfer_clock_pin_out;
         @(negedge ref_clk);
         k += int'(got[0] !== xfer_clock_pin_out);
      end
      `CHK("xck_edges", 10, k)
      $display("test clocked done");
      // broken stop and wrong parity from the peer
      cfg(1'b0, 1'b0, 1'b0, 12'h000, 4'h8, 2'h2);
      peer_u.send(9'h05A, 4'h8, 2'h3, 16, 1'b0, 1'b0);
      wait_rx();
      `CHK("parity_err", 1'b1, parity_error_flag)
      rd(8'h5A, 1'b0, 1'b1);
      $display("test errors done");
      close_out();
   end
endmodule
